// *** pkg/fdc_pkg.sv ***
package fdc_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

    // ==========================================================
    // Register map
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SUB = 12'h004;
    localparam logic [11:0] OFS_LO = 12'h008;
    localparam logic [11:0] OFS_HI = 12'h00c;
    localparam logic [11:0] OFS_CORR = 12'h010;
    localparam logic [11:0] OFS_CMD = 12'h014;
    localparam logic [11:0] OFS_BATCH = 12'h018;
    localparam logic [11:0] OFS_EXP = 12'h01c;
    localparam logic [11:0] OFS_THR = 12'h020;
    localparam logic [11:0] OFS_STATUS = 12'h024;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h028;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h02c;
    localparam logic [11:0] OFS_POS = 12'h030;
    localparam logic [11:0] OFS_NEG = 12'h034;
    localparam logic [11:0] OFS_VIEW = 12'h038;
    localparam logic [11:0] OFS_ZERO = 12'h03c;

    // ==========================================================
    // Limits, scales and reset values
    localparam logic [15:0] PERMILLE = 16'h03e8;
    localparam logic [15:0] SUB_MAX = 16'h03e8;
    localparam logic [15:0] SUB_RST = 16'h0000;
    localparam logic [15:0] CORR_MIN = 16'h01f4;
    localparam logic [15:0] CORR_MAX = 16'h05dc;
    localparam logic [15:0] CORR_RST = 16'h03e8;
    localparam logic [3:0] DWELL_MIN = 4'h1;
    localparam logic [3:0] DWELL_MAX = 4'ha;
    localparam logic [9:0] THR_RST = 10'h032;
    localparam logic [31:0] BATCH_RST = 32'h0000_03e8;
    localparam logic [2:0] EXP_MAX = 3'h6;
    localparam logic [15:0] ERR_LOW_SIG = 16'h0010;
    localparam logic [15:0] ERR_NONE = 16'h0000;

    // ==========================================================
    // Bit positions
    localparam int CMD_ZERO = 0;
    localparam int CMD_DFLT = 1;
    localparam int CMD_TRES = 2;
    localparam int IRQ_ERR_SET = 0;
    localparam int IRQ_ERR_CLR = 1;
    localparam int IRQ_BATCH = 2;
    localparam int IRQ_W = 3;
    localparam int STS_ERR = 0;
    localparam int STS_TOTAL = 1;
    localparam int STS_LOW_SIG = 2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        DISP_RATE = 2'h0,
        DISP_TOTAL = 2'h1,
        DISP_BOTH = 2'h2
    } fdc_disp_t;

    typedef enum logic [1:0] {
        TSEL_POS = 2'h0,
        TSEL_NEG = 2'h1,
        TSEL_NET = 2'h2,
        TSEL_BATCH = 2'h3
    } fdc_tsel_t;

    typedef enum logic [0:0] {
        VIEW_RATE = 1'h0,
        VIEW_TOTAL = 1'h1
    } fdc_view_t;

    typedef struct packed {
        logic [3:0] dwell;
        fdc_tsel_t tsel;
        fdc_disp_t disp;
    } fdc_ctrl_t;

    // Volume units per totalizer count for each exponent setting.
    function automatic logic [31:0] pow10(input logic [2:0] e);
        case (e)
            3'h0: pow10 = 32'h0000_0001;
            3'h1: pow10 = 32'h0000_000a;
            3'h2: pow10 = 32'h0000_0064;
            3'h3: pow10 = 32'h0000_03e8;
            3'h4: pow10 = 32'h0000_2710;
            3'h5: pow10 = 32'h0001_86a0;
            default: pow10 = 32'h000f_4240;
        endcase
    endfunction : pow10

endpackage : fdc_pkg

// *** src/fdc_muldiv.sv ***
`timescale 1ns/1ps

module fdc_muldiv #(
    parameter logic [15:0] DIV = fdc_pkg::PERMILLE
) (
    // Clock and reset
    input logic clock_in,
    input logic rst_n_in,
    // Operands
    input logic signed [31:0] a_in,
    input logic [15:0] b_in,
    // Result
    output logic signed [31:0] q_out
);

    // ==========================================================
    // Scaled product, registered
    localparam logic signed [48:0] DIV_S = 49'(DIV);
    logic signed [48:0] prod;

    assign prod = a_in * $signed({1'b0, b_in});

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            q_out <= 32'sh0;
        end else begin
            q_out <= 32'(prod / DIV_S);
        end
    end

endmodule : fdc_muldiv

// *** src/fdc_top.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - During an error, outputs and displayed rate show the substitute flow value.
// - Substitute flow is a per-mille share of the low-to-high span, capped 0 to 1000.
// - Zero capture records the present measured offset and subtracts it afterwards.
// - Default zero command sets the stored zero offset to zero.
// - Readings are multiplied by a correction of 0.500 to 1.500, reset 1.000.
// - Display selector shows rate only, total only, or alternates both.
// - Each alternating item stays for the dwell interval, 1 to 10 seconds.
// - Total view shows positive, negative, net (positive minus negative) or batch total.
// - Batch mode counts up to the target, returns to zero and repeats.
// - One totalizer count equals ten to the exponent volume units.
// - Low signal error is raised below cutoff and held until strength exceeds it.
module fdc_top #(
    parameter int unsigned TICK_CYCLES = fdc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input logic clock_in,
    input logic rst_n_in,
    // APB slave
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic [11:0] paddr_in,
    input logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Measurement engine
    input logic signed [31:0] flow_raw_in,
    input logic flow_valid_in,
    input logic signed [31:0] offset_meas_in,
    input logic [9:0] signal_strength_in,
    input logic fault_in,
    // Outputs and display
    output logic signed [31:0] analog_flow_out,
    output logic signed [31:0] display_value_out,
    output logic display_total_out,
    output logic [15:0] error_code_out,
    output logic irq_out
);

    // ==========================================================
    // APB access and configuration registers
    fdc_pkg::fdc_ctrl_t ctrl_q;
    logic [15:0] sub_pct_q, corr_q;
    logic signed [31:0] lo_q, hi_q, zero_q;
    logic [31:0] batch_tgt_q;
    logic [2:0] exp_q;
    logic [9:0] thr_q;
    logic [fdc_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev, w1c;
    logic wr, cmd_zero, cmd_dflt, cmd_tres, mapped;
    logic [31:0] rd_d;
    logic [15:0] wlo;

    assign wr = psel_in && penable_in && pwrite_in && pready_out;
    assign wlo = pwdata_in[15:0];
    assign cmd_zero = wr && paddr_in == fdc_pkg::OFS_CMD && pwdata_in[fdc_pkg::CMD_ZERO];
    assign cmd_dflt = wr && paddr_in == fdc_pkg::OFS_CMD && pwdata_in[fdc_pkg::CMD_DFLT];
    assign cmd_tres = wr && paddr_in == fdc_pkg::OFS_CMD && pwdata_in[fdc_pkg::CMD_TRES];
    assign w1c = (wr && paddr_in == fdc_pkg::OFS_IRQ_STAT) ? pwdata_in[fdc_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ctrl_q <= '{dwell: fdc_pkg::DWELL_MIN, tsel: fdc_pkg::TSEL_POS, disp: fdc_pkg::DISP_RATE};
            sub_pct_q <= fdc_pkg::SUB_RST;
            corr_q <= fdc_pkg::CORR_RST;
            lo_q <= 32'sh0;
            hi_q <= 32'sh0;
            batch_tgt_q <= fdc_pkg::BATCH_RST;
            exp_q <= 3'h0;
            thr_q <= fdc_pkg::THR_RST;
            irq_mask_q <= '0;
        end else if (wr) begin
            case (paddr_in)
                fdc_pkg::OFS_CTRL: begin
                    ctrl_q.disp <= fdc_pkg::fdc_disp_t'(pwdata_in[1:0] > 2'h2 ? 2'h2 : pwdata_in[1:0]);
                    ctrl_q.tsel <= fdc_pkg::fdc_tsel_t'(pwdata_in[3:2]);
                    ctrl_q.dwell <= pwdata_in[7:4] < fdc_pkg::DWELL_MIN ? fdc_pkg::DWELL_MIN :
                        pwdata_in[7:4] > fdc_pkg::DWELL_MAX ? fdc_pkg::DWELL_MAX : pwdata_in[7:4];
                end
                fdc_pkg::OFS_SUB: sub_pct_q <= wlo > fdc_pkg::SUB_MAX ? fdc_pkg::SUB_MAX : wlo;
                fdc_pkg::OFS_LO: lo_q <= $signed(pwdata_in);
                fdc_pkg::OFS_HI: hi_q <= $signed(pwdata_in);
                fdc_pkg::OFS_CORR: corr_q <= wlo < fdc_pkg::CORR_MIN ? fdc_pkg::CORR_MIN :
                    wlo > fdc_pkg::CORR_MAX ? fdc_pkg::CORR_MAX : wlo;
                fdc_pkg::OFS_BATCH: batch_tgt_q <= pwdata_in;
                fdc_pkg::OFS_EXP: exp_q <= pwdata_in[2:0] > fdc_pkg::EXP_MAX ? fdc_pkg::EXP_MAX : pwdata_in[2:0];
                fdc_pkg::OFS_THR: thr_q <= pwdata_in[9:0];
                fdc_pkg::OFS_IRQ_MASK: irq_mask_q <= pwdata_in[fdc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events: a new event in the clearing cycle survives the clear.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | irq_ev;
            irq_out <= |(((irq_stat_q & ~w1c) | irq_ev) & irq_mask_q);
        end
    end

    // ==========================================================
    // Zero offset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            zero_q <= 32'sh0;
        end else if (cmd_zero) begin
            zero_q <= offset_meas_in;
        end else if (cmd_dflt) begin
            zero_q <= 32'sh0;
        end
    end

    // ==========================================================
    // Flow path: offset removal, correction, substitute
    logic signed [31:0] net_raw_q, corr_flow, sub_off, sub_val, rate_q;
    logic low_sig_q, low_sig_d, err_now;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            net_raw_q <= 32'sh0;
        end else if (flow_valid_in) begin
            net_raw_q <= flow_raw_in - zero_q;
        end
    end

    fdc_muldiv #(.DIV(fdc_pkg::PERMILLE)) u_corr (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .a_in(net_raw_q),
        .b_in(corr_q),
        .q_out(corr_flow)
    );

    fdc_muldiv #(.DIV(fdc_pkg::PERMILLE)) u_sub (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .a_in(hi_q - lo_q),
        .b_in(sub_pct_q),
        .q_out(sub_off)
    );

    assign sub_val = lo_q + sub_off;

    always_comb begin
        low_sig_d = low_sig_q;
        if (signal_strength_in < thr_q) begin
            low_sig_d = 1'b1;
        end else if (signal_strength_in > thr_q) begin
            low_sig_d = 1'b0;
        end
    end

    assign err_now = low_sig_q || fault_in;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            low_sig_q <= 1'b0;
            error_code_out <= fdc_pkg::ERR_NONE;
            rate_q <= 32'sh0;
        end else begin
            low_sig_q <= low_sig_d;
            error_code_out <= low_sig_d ? fdc_pkg::ERR_LOW_SIG : fdc_pkg::ERR_NONE;
            rate_q <= err_now ? sub_val : corr_flow;
        end
    end

    assign analog_flow_out = rate_q;

    // ==========================================================
    // Seconds tick and display alternation
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [3:0] dwell_cnt_q;
    fdc_pkg::fdc_view_t view_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
            tick_cnt_q <= tick_cnt_q == 32'(TICK_CYCLES - 1) ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            view_q <= fdc_pkg::VIEW_RATE;
            dwell_cnt_q <= 4'h0;
        end else begin
            case (ctrl_q.disp)
                fdc_pkg::DISP_RATE: begin
                    view_q <= fdc_pkg::VIEW_RATE;
                    dwell_cnt_q <= 4'h0;
                end
                fdc_pkg::DISP_TOTAL: begin
                    view_q <= fdc_pkg::VIEW_TOTAL;
                    dwell_cnt_q <= 4'h0;
                end
                fdc_pkg::DISP_BOTH: begin
                    if (tick_q) begin
                        if (dwell_cnt_q + 4'h1 >= ctrl_q.dwell) begin
                            view_q <= view_q == fdc_pkg::VIEW_RATE ? fdc_pkg::VIEW_TOTAL : fdc_pkg::VIEW_RATE;
                            dwell_cnt_q <= 4'h0;
                        end else begin
                            dwell_cnt_q <= dwell_cnt_q + 4'h1;
                        end
                    end
                end
                default: begin
                    view_q <= fdc_pkg::VIEW_RATE;
                    dwell_cnt_q <= 4'h0;
                end
            endcase
        end
    end

    assign display_total_out = view_q == fdc_pkg::VIEW_TOTAL;

    // ==========================================================
    // Totalizers
    // The rate is integrated once a second; excess volume drains one count a cycle, far faster than it fills.
    logic [39:0] scale40;
    logic [39:0] acc_q [2];
    logic [31:0] tot_q [2];
    logic [1:0] count_ev;
    logic [31:0] batch_q;
    logic batch_ev;
    logic signed [31:0] tot_view;

    assign scale40 = 40'(fdc_pkg::pow10(exp_q));

    for (genvar d = 0; d < 2; d++) begin : g_dir
        logic [39:0] add;
        assign add = !tick_q ? 40'h0 :
            (d == 0) ? (rate_q > 32'sh0 ? 40'(rate_q) : 40'h0) : (rate_q < 32'sh0 ? 40'(-rate_q) : 40'h0);
        assign count_ev[d] = acc_q[d] >= scale40;
        always_ff @(posedge clock_in) begin
            if (!rst_n_in || cmd_tres) begin
                acc_q[d] <= 40'h0;
                tot_q[d] <= 32'h0;
            end else begin
                acc_q[d] <= acc_q[d] + add - (count_ev[d] ? scale40 : 40'h0);
                tot_q[d] <= tot_q[d] + 32'(count_ev[d]);
            end
        end
    end

    assign batch_ev = count_ev[0] && batch_q + 32'h1 >= batch_tgt_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || cmd_tres) begin
            batch_q <= 32'h0;
        end else if (count_ev[0]) begin
            batch_q <= batch_ev ? 32'h0 : batch_q + 32'h1;
        end
    end

    always_comb begin
        case (ctrl_q.tsel)
            fdc_pkg::TSEL_POS: tot_view = $signed(tot_q[0]);
            fdc_pkg::TSEL_NEG: tot_view = $signed(tot_q[1]);
            fdc_pkg::TSEL_NET: tot_view = $signed(tot_q[0] - tot_q[1]);
            default: tot_view = $signed(batch_q);
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            display_value_out <= 32'sh0;
        end else begin
            display_value_out <= view_q == fdc_pkg::VIEW_TOTAL ? tot_view : rate_q;
        end
    end

    assign irq_ev[fdc_pkg::IRQ_ERR_SET] = low_sig_d && !low_sig_q;
    assign irq_ev[fdc_pkg::IRQ_ERR_CLR] = !low_sig_d && low_sig_q;
    assign irq_ev[fdc_pkg::IRQ_BATCH] = batch_ev;

    // ==========================================================
    // APB read and answer
    always_comb begin
        rd_d = 32'h0;
        mapped = 1'b1;
        case (paddr_in)
            fdc_pkg::OFS_CTRL: rd_d = 32'(ctrl_q);
            fdc_pkg::OFS_SUB: rd_d = 32'(sub_pct_q);
            fdc_pkg::OFS_LO: rd_d = lo_q;
            fdc_pkg::OFS_HI: rd_d = hi_q;
            fdc_pkg::OFS_CORR: rd_d = 32'(corr_q);
            fdc_pkg::OFS_CMD: rd_d = 32'h0;
            fdc_pkg::OFS_BATCH: rd_d = batch_tgt_q;
            fdc_pkg::OFS_EXP: rd_d = 32'(exp_q);
            fdc_pkg::OFS_THR: rd_d = 32'(thr_q);
            fdc_pkg::OFS_STATUS: rd_d = 32'({low_sig_q, display_total_out, err_now});
            fdc_pkg::OFS_IRQ_STAT: rd_d = 32'(irq_stat_q);
            fdc_pkg::OFS_IRQ_MASK: rd_d = 32'(irq_mask_q);
            fdc_pkg::OFS_POS: rd_d = tot_q[0];
            fdc_pkg::OFS_NEG: rd_d = tot_q[1];
            fdc_pkg::OFS_VIEW: rd_d = tot_view;
            fdc_pkg::OFS_ZERO: rd_d = zero_q;
            default: mapped = 1'b0;
        endcase
    end

    // The answer is prepared in the setup cycle so that every bus output leaves a flip-flop.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped;
            prdata_out <= (psel_in && !penable_in && !pwrite_in) ? rd_d : 32'h0;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    chk_sub_on_error: assert property (err_now |=> analog_flow_out == $past(sub_val))
        else $error("substitute flow not driven during error");
    chk_sub_pct_cap: assert property (sub_pct_q <= fdc_pkg::SUB_MAX)
        else $error("substitute share above limit");
    chk_zero_capture: assert property (cmd_zero |=> zero_q == $past(offset_meas_in))
        else $error("zero offset not captured");
    chk_default_zero: assert property (cmd_dflt && !cmd_zero |=> zero_q == 32'sh0)
        else $error("default zero not applied");
    chk_corr_range: assert property (corr_q >= fdc_pkg::CORR_MIN && corr_q <= fdc_pkg::CORR_MAX)
        else $error("correction outside range");
    chk_fixed_view: assert property (ctrl_q.disp == fdc_pkg::DISP_RATE |=> !display_total_out)
        else $error("total shown in rate only mode");
    chk_dwell_hold: assert property (ctrl_q.disp == fdc_pkg::DISP_BOTH && $changed(view_q)
        |=> (dwell_cnt_q == 4'h0 && ($stable(view_q) || $past(ctrl_q.disp) != fdc_pkg::DISP_BOTH)) [*2])
        else $error("view switched without dwell");
    chk_net_total: assert property (view_q == fdc_pkg::VIEW_TOTAL && ctrl_q.tsel == fdc_pkg::TSEL_NET
        |=> display_value_out == $signed($past(tot_q[0]) - $past(tot_q[1])))
        else $error("net total wrong");
    chk_batch_wrap: assert property (batch_ev && !cmd_tres |=> batch_q == 32'h0)
        else $error("batch did not wrap");
    chk_count_scale: assert property (acc_q[0] >= scale40 && !cmd_tres
        |=> tot_q[0] == $past(tot_q[0]) + 32'h1)
        else $error("count not taken at scaled volume");
    chk_low_sig_hold: assert property (low_sig_q && signal_strength_in <= thr_q
        |=> low_sig_q && error_code_out == fdc_pkg::ERR_LOW_SIG)
        else $error("low signal error dropped early");
    chk_dwell_count: assert property (!tick_q && ctrl_q.disp == fdc_pkg::DISP_BOTH
        |=> $stable(dwell_cnt_q))
        else $error("dwell counted without tick");

    cov_alternate: cover property (ctrl_q.disp == fdc_pkg::DISP_BOTH && $changed(view_q));
    cov_batch_wrap: cover property (batch_ev);
    cov_error_sub: cover property (low_sig_q ##1 !low_sig_q);
    cov_irq: cover property ($rose(irq_out));

endmodule : fdc_top

// *** dv/fdc_panel_model.sv ***
`timescale 1ns/1ps

// ==========================================
// Local display model: times how long each view is shown.
module fdc_panel_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Display side
    input wire logic display_total_in,
    // Observations
    output int gap_out,
    output int switches_out
);
    int run_q;
    logic last_q;

    // A switch restarts the run count, so gap_out holds one full dwell.
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            run_q <= 0;
            gap_out <= 0;
            switches_out <= 0;
            last_q <= 1'b0;
        end else begin
            last_q <= display_total_in;
            run_q <= run_q + 1;
            if (display_total_in !== last_q) begin
                gap_out <= run_q;
                run_q <= 1;
                switches_out <= switches_out + 1;
            end
        end
    end
endmodule : fdc_panel_model

// *** dv/test_flow_total_display_control.sv ***
`timescale 1ns/1ps

module test_flow_total_display_control;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } fdc_row_t;
    localparam int TICK = 20;
    logic clock_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd, pos_v, neg_v;
    logic signed [31:0] flow_raw_in, offset_meas_in, analog_flow_out, display_value_out;
    logic flow_valid_in, fault_in, display_total_out, irq_out, er;
    logic [9:0] signal_strength_in;
    logic [15:0] error_code_out;
    int gap, switches, n_mismatch, tests_run, cyc;
    fdc_row_t rows[7] = '{
        '{fdc_pkg::OFS_CTRL, 32'h0000_00f3, 32'h0000_00a2, 1'b0},
        '{fdc_pkg::OFS_CTRL, 32'h0000_0000, 32'h0000_0010, 1'b0},
        '{fdc_pkg::OFS_SUB, 32'h0000_04b0, 32'h0000_03e8, 1'b0},
        '{fdc_pkg::OFS_CORR, 32'h0000_0190, 32'h0000_01f4, 1'b0},
        '{fdc_pkg::OFS_CORR, 32'h0000_07d0, 32'h0000_05dc, 1'b0},
        '{fdc_pkg::OFS_EXP, 32'h0000_0007, 32'h0000_0006, 1'b0},
        '{12'h040, 32'h0000_0001, 32'h0000_0000, 1'b1}
    };

    fdc_top #(.TICK_CYCLES(TICK)) DUT (.clock_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .flow_raw_in, .flow_valid_in, .offset_meas_in,
        .signal_strength_in, .fault_in, .analog_flow_out, .display_value_out, .display_total_out,
        .error_code_out, .irq_out);
    fdc_panel_model panel (.clock_in(clock_in), .rst_n_in(rst_n_in), .display_total_in(display_total_out),
        .gap_out(gap), .switches_out(switches));

    // ==========================================
    // Checks and bus tasks
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk

    // Waits an edge first so back-to-back calls never assign psel twice at once.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        @(posedge clock_in);
        while (pready_out !== 1'b1 && n < 50) begin
            n++;
            @(posedge clock_in);
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        chk(n < 50, "no ready");
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd === e, $sformatf("read %h got %h", a, rd));
    endtask : rdchk

    task automatic wt(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wt

    task automatic test_done;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        {cyc, n_mismatch, tests_run} = '0;
        {rst_n_in, psel_in, penable_in, pwrite_in, fault_in, paddr_in, pwdata_in, offset_meas_in} = '0;
        flow_valid_in = 1'b1;
        flow_raw_in = 32'sh0000_07d0;
        signal_strength_in = 10'h064;
        wt(10);
        rst_n_in <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].rdata);
            chk(er === rows[i].err, "slave error flag");
        end
        rst_n_in <= 1'b0;
        wt(2);
        chk({analog_flow_out, irq_out, pready_out} === '0, "outputs not cleared in reset");
        rst_n_in <= 1'b1;
        rdchk(fdc_pkg::OFS_CORR, 32'h0000_03e8);
        wt(10);
        chk(analog_flow_out === 32'sh0000_07d0, "plain flow");
        apb(1'b1, fdc_pkg::OFS_CORR, 32'h0000_01f4);
        offset_meas_in <= 32'sh0000_01f4;
        apb(1'b1, fdc_pkg::OFS_CMD, 32'h0000_0001);
        wt(10);
        chk(analog_flow_out === 32'sh0000_02ee, "captured zero");
        apb(1'b1, fdc_pkg::OFS_CMD, 32'h0000_0002);
        rdchk(fdc_pkg::OFS_ZERO, 32'h0);
        wt(10);
        chk(analog_flow_out === 32'sh0000_03e8, "default zero");
        apb(1'b1, fdc_pkg::OFS_LO, 32'hffff_fe0c);
        apb(1'b1, fdc_pkg::OFS_HI, 32'h0000_05dc);
        apb(1'b1, fdc_pkg::OFS_SUB, 32'h0000_01f4);
        apb(1'b1, fdc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        fault_in <= 1'b1;
        wt(6);
        chk(analog_flow_out === 32'sh01f4 && display_value_out === 32'sh01f4, "substitute");
        fault_in <= 1'b0;
        signal_strength_in <= 10'h00a;
        wt(4);
        chk(error_code_out === 16'h0010 && irq_out === 1'b1, "low signal raise");
        signal_strength_in <= 10'h032;
        wt(6);
        chk(error_code_out === 16'h0010 && analog_flow_out === 32'sh01f4, "low signal hold");
        signal_strength_in <= 10'h033;
        wt(4);
        chk(error_code_out === 16'h0000, "low signal clear");
        apb(1'b1, fdc_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        wt(2);
        chk(irq_out === 1'b0, "irq clear");
        apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_0011);
        wt(3);
        chk(display_total_out === 1'b1, "total only");
        apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_0022);
        wt(10 * TICK);
        chk(gap === 2 * TICK && switches > 2, "dwell period");
        apb(1'b1, fdc_pkg::OFS_EXP, 32'h0000_0002);
        apb(1'b1, fdc_pkg::OFS_BATCH, 32'h0000_0019);
        apb(1'b1, fdc_pkg::OFS_CMD, 32'h0000_0004);
        wt(20 * TICK);
        flow_raw_in <= 32'sh0;
        wt(2 * TICK);
        apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_0018);
        apb(1'b0, fdc_pkg::OFS_POS, 32'h0);
        chk(rd > 32'h0 && rd % 32'ha === 32'h0, "scaled count");
        rdchk(fdc_pkg::OFS_VIEW, rd);
        rdchk(fdc_pkg::OFS_NEG, 32'h0);
        apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_001c);
        apb(1'b0, fdc_pkg::OFS_VIEW, 32'h0);
        chk(rd < 32'h19, "batch below target");
        apb(1'b0, fdc_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rd[fdc_pkg::IRQ_BATCH] === 1'b1, "batch wrap seen");
        // Reverse flow fills the negative total, then net must be positive minus negative.
        flow_raw_in <= 32'shffff_f830;
        wt(2 * TICK);
        flow_raw_in <= 32'sh0;
        wt(2 * TICK);
        apb(1'b0, fdc_pkg::OFS_POS, 32'h0);
        pos_v = rd;
        apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_0014);
        apb(1'b0, fdc_pkg::OFS_VIEW, 32'h0);
        neg_v = rd;
        chk(neg_v > 32'h0 && neg_v % 32'ha === 32'h0, "negative total");
        apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_0018);
        rdchk(fdc_pkg::OFS_VIEW, pos_v - neg_v);
        test_done();
    end
endmodule : test_flow_total_display_control
